// >>> src/airc_core.sv
// inverse row rotate, inverse byte substitute, carry-less multiply, feature flags
`include "airc_params.svh"

module airc_core (
  input wire logic clock,
  input wire logic rst,
  input wire airc_pkg::airc_req_t req,
  output airc_pkg::airc_rsp_t rsp
);
  import airc_pkg::*;

  localparam logic [7:0] INV_TABLE [256] = '{
    8'h52, 8'h09, 8'h6A, 8'hD5, 8'h30, 8'h36, 8'hA5, 8'h38,
    8'hBF, 8'h40, 8'hA3, 8'h9E, 8'h81, 8'hF3, 8'hD7, 8'hFB,
    8'h7C, 8'hE3, 8'h39, 8'h82, 8'h9B, 8'h2F, 8'hFF, 8'h87,
    8'h34, 8'h8E, 8'h43, 8'h44, 8'hC4, 8'hDE, 8'hE9, 8'hCB,
    8'h54, 8'h7B, 8'h94, 8'h32, 8'hA6, 8'hC2, 8'h23, 8'h3D,
    8'hEE, 8'h4C, 8'h95, 8'h0B, 8'h42, 8'hFA, 8'hC3, 8'h4E,
    8'h08, 8'h2E, 8'hA1, 8'h66, 8'h28, 8'hD9, 8'h24, 8'hB2,
    8'h76, 8'h5B, 8'hA2, 8'h49, 8'h6D, 8'h8B, 8'hD1, 8'h25,
    8'h72, 8'hF8, 8'hF6, 8'h64, 8'h86, 8'h68, 8'h98, 8'h16,
    8'hD4, 8'hA4, 8'h5C, 8'hCC, 8'h5D, 8'h65, 8'hB6, 8'h92,
    8'h6C, 8'h70, 8'h48, 8'h50, 8'hFD, 8'hED, 8'hB9, 8'hDA,
    8'h5E, 8'h15, 8'h46, 8'h57, 8'hA7, 8'h8D, 8'h9D, 8'h84,
    8'h90, 8'hD8, 8'hAB, 8'h00, 8'h8C, 8'hBC, 8'hD3, 8'h0A,
    8'hF7, 8'hE4, 8'h58, 8'h05, 8'hB8, 8'hB3, 8'h45, 8'h06,
    8'hD0, 8'h2C, 8'h1E, 8'h8F, 8'hCA, 8'h3F, 8'h0F, 8'h02,
    8'hC1, 8'hAF, 8'hBD, 8'h03, 8'h01, 8'h13, 8'h8A, 8'h6B,
    8'h3A, 8'h91, 8'h11, 8'h41, 8'h4F, 8'h67, 8'hDC, 8'hEA,
    8'h97, 8'hF2, 8'hCF, 8'hCE, 8'hF0, 8'hB4, 8'hE6, 8'h73,
    8'h96, 8'hAC, 8'h74, 8'h22, 8'hE7, 8'hAD, 8'h35, 8'h85,
    8'hE2, 8'hF9, 8'h37, 8'hE8, 8'h1C, 8'h75, 8'hDF, 8'h6E,
    8'h47, 8'hF1, 8'h1A, 8'h71, 8'h1D, 8'h29, 8'hC5, 8'h89,
    8'h6F, 8'hB7, 8'h62, 8'h0E, 8'hAA, 8'h18, 8'hBE, 8'h1B,
    8'hFC, 8'h56, 8'h3E, 8'h4B, 8'hC6, 8'hD2, 8'h79, 8'h20,
    8'h9A, 8'hDB, 8'hC0, 8'hFE, 8'h78, 8'hCD, 8'h5A, 8'hF4,
    8'h1F, 8'hDD, 8'hA8, 8'h33, 8'h88, 8'h07, 8'hC7, 8'h31,
    8'hB1, 8'h12, 8'h10, 8'h59, 8'h27, 8'h80, 8'hEC, 8'h5F,
    8'h60, 8'h51, 8'h7F, 8'hA9, 8'h19, 8'hB5, 8'h4A, 8'h0D,
    8'h2D, 8'hE5, 8'h7A, 8'h9F, 8'h93, 8'hC9, 8'h9C, 8'hEF,
    8'hA0, 8'hE0, 8'h3B, 8'h4D, 8'hAE, 8'h2A, 8'hF5, 8'hB0,
    8'hC8, 8'hEB, 8'hBB, 8'h3C, 8'h83, 8'h53, 8'h99, 8'h61,
    8'h17, 8'h2B, 8'h04, 8'h7E, 8'hBA, 8'h77, 8'hD6, 8'h26,
    8'hE1, 8'h69, 8'h14, 8'h63, 8'h55, 8'h21, 8'h0C, 8'h7D
  };

  airc_state_t state_q;
  airc_state_t state_d;
  logic [127:0] rotated;
  logic [127:0] substituted;
  logic [127:0] clmul_chain [`AIRC_OPND_W+1];
  logic [31:0] feature_word;

  // byte n holds row n%4, column n/4
  for (genvar n = 0; n < `AIRC_BYTES; n++)
  begin : g_byte
    localparam int ROW = n % `AIRC_ROWS;
    localparam int COL = n / `AIRC_ROWS;
    localparam int SRC = `AIRC_ROWS * ((COL + `AIRC_ROWS - ROW) % `AIRC_ROWS) + ROW;
    assign rotated[`AIRC_BYTE_W*n +: `AIRC_BYTE_W] =
      req.operand_a[`AIRC_BYTE_W*SRC +: `AIRC_BYTE_W];
    // upper nibble picks table row, lower nibble picks column
    assign substituted[`AIRC_BYTE_W*n +: `AIRC_BYTE_W] =
      INV_TABLE[req.operand_a[`AIRC_BYTE_W*n +: `AIRC_BYTE_W]];
  end

  // one shifted copy of operand a per set bit of operand b, folded by xor
  assign clmul_chain[0] = '0;
  for (genvar k = 0; k < `AIRC_OPND_W; k++)
  begin : g_clmul
    assign clmul_chain[k+1] = clmul_chain[k] ^
      (req.operand_b[k] ? ({64'h0, req.operand_a[63:0]} << k) : 128'h0);
  end

  always_comb
  begin
    feature_word = '0;
    if (req.operand_a[31:0] == `AIRC_LEAF_BASIC)
    begin
      feature_word[`AIRC_FEAT_AES_BIT] = 1'b1;
      feature_word[`AIRC_FEAT_CLMUL_BIT] = 1'b1;
    end
  end

  always_comb
  begin
    state_d = state_q;
    state_d.valid = req.valid;
    if (req.valid)
    begin
      case (req.op)
        AIRC_OP_INV_ROTATE: state_d.result = rotated;
        AIRC_OP_INV_SUBST: state_d.result = substituted;
        AIRC_OP_CLMUL: state_d.result = clmul_chain[`AIRC_OPND_W];
        AIRC_OP_FEATURE: state_d.result = {96'h0, feature_word};
        default: state_d.result = '0;
      endcase
    end
  end

  always_ff @(posedge clock or posedge rst)
  begin
    if (rst)
      state_q <= `AIRC_STATE_RESET;
    else
      state_q <= state_d;
  end

  assign rsp.valid = state_q.valid;
  assign rsp.result = state_q.result;

  default clocking cb @(posedge clock); endclocking
  default disable iff (rst);

  sequence s_issue(airc_op_t o);
    req.valid && req.op == o;
  endsequence

  sequence s_answer;
    rsp.valid;
  endsequence

  result_latency_a: assert property (req.valid |=> s_answer)
    else $error("result strobe missing one cycle after request");

  no_spurious_a: assert property (!req.valid |=> !rsp.valid)
    else $error("result strobe without request");

  row_zero_a: assert property (s_issue(AIRC_OP_INV_ROTATE) |=>
    rsp.result[7:0] == $past(req.operand_a[7:0])
    && rsp.result[39:32] == $past(req.operand_a[39:32]))
    else $error("inverse rotate disturbed row zero");

  row_shift_a: assert property (s_issue(AIRC_OP_INV_ROTATE) |=>
    rsp.result[15:8] == $past(req.operand_a[111:104])
    && rsp.result[23:16] == $past(req.operand_a[87:80])
    && rsp.result[31:24] == $past(req.operand_a[63:56]))
    else $error("inverse rotate moved rows by wrong amount");

  row_mid_a: assert property (s_issue(AIRC_OP_INV_ROTATE) |=>
    rsp.result[71:64] == $past(req.operand_a[71:64])
    && rsp.result[103:96] == $past(req.operand_a[103:96])
    && rsp.result[47:40] == $past(req.operand_a[15:8])
    && rsp.result[55:48] == $past(req.operand_a[119:112])
    && rsp.result[63:56] == $past(req.operand_a[95:88])
    && rsp.result[79:72] == $past(req.operand_a[47:40])
    && rsp.result[87:80] == $past(req.operand_a[23:16])
    && rsp.result[95:88] == $past(req.operand_a[127:120]))
    else $error("inverse rotate middle columns wrong");

  row_tail_a: assert property (s_issue(AIRC_OP_INV_ROTATE) |=>
    rsp.result[111:104] == $past(req.operand_a[79:72])
    && rsp.result[119:112] == $past(req.operand_a[55:48])
    && rsp.result[127:120] == $past(req.operand_a[31:24]))
    else $error("inverse rotate last column wrong");

  // substitution probes: fixed bytes with known table entries
  table_values_a: assert property (
    s_issue(AIRC_OP_INV_SUBST) ##0 req.operand_a[15:0] == 16'hFF00
    ##1 s_answer |-> rsp.result[15:0] == 16'h7D52)
    else $error("inverse table value wrong");

  nibble_index_a: assert property (
    s_issue(AIRC_OP_INV_SUBST) ##0 req.operand_a[127:120] == 8'h01
    |=> rsp.result[127:120] == 8'h09)
    else $error("inverse table indexing wrong");

  nibble_row_a: assert property (
    s_issue(AIRC_OP_INV_SUBST) ##0 req.operand_a[23:16] == 8'h10
    |=> rsp.result[23:16] == 8'h7C)
    else $error("inverse table row select wrong");

  undo_forward_a: assert property (
    s_issue(AIRC_OP_INV_SUBST) ##0 req.operand_a[15:0] == 16'h7C63
    |=> rsp.result[15:0] == 16'h0100)
    else $error("inverse substitution does not undo forward");

  clmul_identity_a: assert property (
    s_issue(AIRC_OP_CLMUL) ##0 req.operand_b == 64'h1
    |=> rsp.result == {64'h0, $past(req.operand_a[63:0])})
    else $error("carry-less product by one wrong");

  clmul_zero_a: assert property (
    s_issue(AIRC_OP_CLMUL) ##0 req.operand_b == '0
    |=> rsp.result == '0)
    else $error("carry-less product by zero not zero");

  clmul_nocarry_a: assert property (
    s_issue(AIRC_OP_CLMUL) ##0 req.operand_a[63:0] == 64'h3 && req.operand_b == 64'h3
    ##1 s_answer |-> rsp.result == 128'h5)
    else $error("carry-less product propagated a carry");

  // top coefficients meet at degree 126, the highest term of the product
  clmul_top_a: assert property (
    s_issue(AIRC_OP_CLMUL)
    ##0 req.operand_a[63:0] == 64'h8000_0000_0000_0000
    && req.operand_b == 64'h8000_0000_0000_0000
    |=> rsp.result == 128'h4000_0000_0000_0000_0000_0000_0000_0000)
    else $error("carry-less product lost its top term");

  feature_bits_a: assert property (
    s_issue(AIRC_OP_FEATURE) ##0 req.operand_a[31:0] == `AIRC_LEAF_BASIC
    |=> rsp.result[`AIRC_FEAT_AES_BIT] && rsp.result[`AIRC_FEAT_CLMUL_BIT])
    else $error("feature flags not reported");

  feature_other_a: assert property (
    s_issue(AIRC_OP_FEATURE) ##0 req.operand_a[31:0] != `AIRC_LEAF_BASIC
    |=> rsp.result == '0)
    else $error("feature flags reported for another leaf");

  feature_upper_a: assert property (s_issue(AIRC_OP_FEATURE) |=>
    rsp.result[127:32] == '0)
    else $error("feature result upper words not zero");

  // back-to-back requests give back-to-back strobes
  sequence s_pair;
    req.valid ##1 req.valid;
  endsequence

  back_to_back_a: assert property (s_pair |=> s_answer)
    else $error("second of two back-to-back results missing");

  result_hold_a: assert property (!req.valid |=> $stable(rsp.result))
    else $error("result changed without request");

  // reset must quiet the outputs whatever the request lines show
  reset_quiet_a: assert property (disable iff (1'b0)
    rst |=> !rsp.valid && rsp.result == '0)
    else $error("outputs not cleared by reset");

endmodule // airc_core

// >>> src/airc_params.svh
// constants for the inverse-round and carry-less multiply datapath
`ifndef AIRC_PARAMS_SVH
`define AIRC_PARAMS_SVH
`define AIRC_ROWS 4
`define AIRC_BYTES 16
`define AIRC_BYTE_W 8
`define AIRC_OPND_W 64
`define AIRC_PROD_W 128
`define AIRC_LEAF_BASIC 32'h0000_0001
`define AIRC_FEAT_AES_BIT 25
`define AIRC_FEAT_CLMUL_BIT 1
`define AIRC_STATE_RESET '0
`endif

// >>> src/airc_pkg.sv
// types for the inverse-round and carry-less multiply datapath
package airc_pkg;
  typedef enum logic [1:0] {
    AIRC_OP_INV_ROTATE,
    AIRC_OP_INV_SUBST,
    AIRC_OP_CLMUL,
    AIRC_OP_FEATURE
  } airc_op_t;

  typedef struct packed {
    logic valid;
    airc_op_t op;
    logic [127:0] operand_a;
    logic [63:0] operand_b;
  } airc_req_t;

  typedef struct packed {
    logic valid;
    logic [127:0] result;
  } airc_rsp_t;

  typedef struct packed {
    logic valid;
    logic [127:0] result;
  } airc_state_t;
endpackage

// >>> tb/airc_core_tb_top.sv
// self-checking bench for the inverse-round and carry-less multiply datapath
module airc_core_tb_top;
  import airc_pkg::*;
  timeunit 1ns;
  timeprecision 1ps;
  logic clock = 1'b0;
  logic rst = 1'b1;
  airc_req_t req;
  airc_rsp_t rsp;
  logic [127:0] exp_q[$];
  int errors = 0;
  int check_count = 0;
  logic [7:0] sin[7] = '{8'h00, 8'h01, 8'hFF, 8'h63, 8'h7C, 8'h10, 8'h53};
  logic [7:0] sout[7] = '{8'h52, 8'h09, 8'h7D, 8'h00, 8'h01, 8'h7C, 8'h50};
  initial
  begin
    forever #2 clock = ~clock;
  end
  airc_pipe_model pipe (.clock(clock), .req(req));
  airc_core dut (.clock(clock), .rst(rst), .req(req), .rsp(rsp));
  function automatic logic [127:0] rot(input logic [127:0] s);
    for (int n = 0; n < 16; n++)
      rot[8*n +: 8] = s[8*(4*((n/4 - n%4 + 4) % 4) + n%4) +: 8];
  endfunction
  function automatic logic [127:0] clm(input logic [63:0] a, input logic [63:0] b);
    clm = '0;
    for (int k = 0; k < 64; k++)
      if (b[k])
        clm ^= {64'h0, a} << k;
  endfunction
  function automatic logic [127:0] isub(input logic [127:0] s);
    for (int n = 0; n < 16; n++)
      for (int t = 0; t < 7; t++)
        if (s[8*n +: 8] == sin[t])
          isub[8*n +: 8] = sout[t];
  endfunction
  // state built only from bytes whose inverse the bench knows
  function automatic logic [127:0] tstate();
    for (int n = 0; n < 16; n++)
      tstate[8*n +: 8] = sin[$urandom_range(0, 6)];
  endfunction
  task automatic issue(input airc_op_t op, input logic [127:0] a, input logic [63:0] b);
    case (op)
      AIRC_OP_INV_ROTATE: exp_q.push_back(rot(a));
      AIRC_OP_CLMUL: exp_q.push_back(clm(a[63:0], b));
      AIRC_OP_FEATURE: exp_q.push_back((a[31:0] == 32'h1) ? 128'h200_0002 : 128'h0);
      default: exp_q.push_back(isub(a));
    endcase
    pipe.send(op, a, b);
  endtask
  task automatic cmp(input logic [127:0] got, input logic [127:0] exp);
    check_count++;
    if (got !== exp)
    begin
      errors++;
      $display("[FAIL] %0t result %h expected %h", $time, got, exp);
    end
  endtask
  always @(negedge clock)
    if (!rst && rsp.valid === 1'b1)
    begin
      if (exp_q.size() == 0)
        cmp(rsp.result, 128'hX);
      else
        cmp(rsp.result, exp_q.pop_front());
    end
  task automatic end_test(input string name);
    pipe.idle();
    repeat (3) @(posedge clock);
    cmp({96'h0, 32'(exp_q.size())}, 128'h0);
    $display("test %s done", name);
  endtask
  task automatic stop_test();
    $display("checks %0d errors %0d", check_count, errors);
    if (errors == 0 && check_count > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask
  initial
  begin
    repeat (20000) @(posedge clock);
    errors++;
    stop_test();
  end
  initial
  begin
    void'($urandom(32'hBF20));
    repeat (6) @(posedge clock);
    rst <= 1'b0;
    repeat (8) issue(AIRC_OP_INV_ROTATE, {$urandom, $urandom, $urandom, $urandom}, 64'h0);
    end_test("rotate");
    repeat (8) issue(AIRC_OP_INV_SUBST, tstate(), 64'h0);
    issue(AIRC_OP_INV_SUBST, {8'h01, 96'h0, 8'h10, 8'hFF, 8'h00}, 64'h0);
    issue(AIRC_OP_INV_SUBST, {112'h0, 16'h7C63}, 64'h0);
    end_test("substitute");
    issue(AIRC_OP_CLMUL, {64'h0, 64'hFFFF_FFFF_FFFF_FFFF}, 64'hFFFF_FFFF_FFFF_FFFF);
    repeat (8) issue(AIRC_OP_CLMUL, {$urandom, $urandom, $urandom, $urandom}, {$urandom, $urandom});
    issue(AIRC_OP_CLMUL, {$urandom, $urandom, $urandom, $urandom}, 64'h1);
    issue(AIRC_OP_CLMUL, 128'h3, 64'h3);
    issue(AIRC_OP_CLMUL, 128'h8000_0000_0000_0000, 64'h8000_0000_0000_0000);
    issue(AIRC_OP_CLMUL, {$urandom, $urandom, $urandom, $urandom}, 64'h0);
    end_test("multiply");
    foreach (sin[t]) issue(AIRC_OP_FEATURE, {96'h0, 24'h0, sin[t]}, 64'h0);
    issue(AIRC_OP_FEATURE, 128'h101, 64'h0);
    end_test("feature");
    repeat (3) issue(AIRC_OP_INV_ROTATE, tstate(), 64'h0);
    rst <= 1'b1;
    exp_q.delete();
    pipe.idle();
    @(negedge clock);
    cmp({127'h0, rsp.valid}, 128'h0);
    cmp(rsp.result, 128'h0);
    @(posedge clock);
    rst <= 1'b0;
    repeat (2) issue(AIRC_OP_FEATURE, 128'h1, 64'h0);
    end_test("reset");
    repeat (40) issue(airc_op_t'($urandom_range(0, 3)), tstate(), {$urandom, $urandom});
    end_test("mixed");
    stop_test();
  end
endmodule // airc_core_tb_top

// >>> tb/airc_pipe_model.sv
// pipeline model that issues operations to the datapath
module airc_pipe_model (
  input wire logic clock,
  output airc_pkg::airc_req_t req
);
  import airc_pkg::*;
  timeunit 1ns;
  timeprecision 1ps;
  initial req = '0;
  task automatic send(input airc_op_t op, input logic [127:0] a, input logic [63:0] b);
    @(posedge clock);
    req <= '{valid: 1'b1, op: op, operand_a: a, operand_b: b};
  endtask
  task automatic idle();
    @(posedge clock);
    req <= '0;
  endtask
endmodule // airc_pipe_model
